// file: glc_pkg.sv
// Package: constants and types for the listener command decoder
package glc_pkg;
   // Bus timing
   localparam int CLK_MHZ = 40;
   localparam int SETTLE_NS = 2000;
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int STROBE_NS = 300;
   localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ) / 1000;
   // AHB register offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_TUNE = 8'h08;
   localparam logic [7:0] ADDR_SHIFT = 8'h0C;
   // Reset values
   localparam logic [4:0] ADDR_RST = 5'h00;
   localparam logic [15:0] TUNE_RST = 16'h0000;
   // Characters
   localparam logic [6:0] CH_UNL = 7'h3F;
   localparam logic [6:0] CH_R = 7'h52;
   localparam logic [6:0] CH_L = 7'h4C;
   localparam logic [6:0] CH_M = 7'h4D;
   localparam logic [6:0] CH_B = 7'h42;
   localparam logic [6:0] CH_V = 7'h56;
   localparam logic [6:0] CH_E = 7'h45;
   localparam logic [1:0] LAG_GRP = 2'h1;
   // Handshake states
   typedef enum logic [1:0] {HS_IDLE, HS_SETTLE, HS_HELD} glc_hs_e;
   // Decoded character
   typedef struct packed {
      logic listen;
      logic unlisten;
      logic ch_r;
      logic ch_l;
      logic ch_m;
      logic ch_b;
      logic ch_v;
      logic ch_e;
      logic digit;
   } glc_dec_s;
endpackage

// file: glc_listener.sv
// Listen-only bus interface with character decoder and tuning register
//
// Contract
// RULE_01: Handshake is enabled while attention is asserted or the listen state is set.
// RULE_02: NRFD and NDAC are driven only while the handshake is enabled.
// RULE_03: After DAV low, wait 2 us settle, then drive NRFD low, release NDAC.
// RULE_04: DAV returning high clears handshake state and releases NRFD.
// RULE_05: One short 0.3 us data strobe per accepted byte while listening or addressed.
// RULE_06: In command mode compare data lines 1..5 with switch address.
// RULE_07: Under attention decode listen characters and question mark unlisten only.
// RULE_08: In data mode decode all seven lines into one character output.
// RULE_09: Strobe sets listen on match without unlisten; clears on unlisten without match.
// RULE_10: Listen clears at once on interface clear low or reset.
// RULE_11: Remote sets on match or strobe with REN low; clears only on REN high.
// RULE_12: R with strobe sets marker state, L clears it; inverted drives marker enable.
// RULE_13: Marker state also clears when REN deasserts and remote falls.
// RULE_14: Remote disables local mode; M captured at strobe end gates next strobe.
// RULE_15: Delayed strobe after M drives one of four active-low mode lines.
// RULE_16: Digit 1 to 4 after M latches the remote converter enable high.
// RULE_17: B captured at strobe end gates next strobe into band latch enable.
// RULE_18: Band digit follows B; exactly one band select output is driven. The code keeps band_sel at 0 until the first band digit.
// RULE_19: V sets voltage entry and clears the four digit shift register.
// RULE_20: Each digit shifts its low nibble into the first digit, sixteen bits total.
// RULE_21: E with strobe loads all four digits to storage and clears entry state.
// RULE_22: Storage register drives the tuning converter, codes 0000 to 9999.
// RULE_23: E, B or M during entry clears entry and loads the storage register.
// RULE_24: Bus inputs are synchronous; delays are counted clock cycles. The code clears listen asynchronously on ifc_n.
// RULE_25: Reset clears all states and leaves NRFD and NDAC released.
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module glc_listener #(
   parameter int SETTLE = glc_pkg::SETTLE_CYC,
   parameter int STROBE = glc_pkg::STROBE_CYC
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Bus lines, active low as on the cable
   input wire logic atn_n,
   input wire logic dav_n,
   input wire logic ifc_n,
   input wire logic ren_n,
   input wire logic [6:0] dio_n,
   output logic nrfd_o,
   output logic nrfd_oe_n,
   output logic ndac_o,
   output logic ndac_oe_n,
   // Instrument controls
   output logic remote_o,
   output logic listen_o,
   output logic remote_marker_enable_n,
   output logic local_mode_disable_n,
   output logic [3:0] mode_sel_n,
   output logic remote_converter_enable,
   output logic remote_band_latch_enable,
   output logic [3:0] band_sel,
   output logic [15:0] tune_code
);
   // Character decode, used for both modes
   function automatic glc_pkg::glc_dec_s decode(input logic atn, input logic [6:0] c);
      glc_pkg::glc_dec_s d;
      d = '0;
      if (atn) begin // RULE_07
         d.listen = (c[6:5] == glc_pkg::LAG_GRP) && (c != glc_pkg::CH_UNL);
         d.unlisten = (c == glc_pkg::CH_UNL);
      end else begin // RULE_08
         d.ch_r = (c == glc_pkg::CH_R);
         d.ch_l = (c == glc_pkg::CH_L);
         d.ch_m = (c == glc_pkg::CH_M);
         d.ch_b = (c == glc_pkg::CH_B);
         d.ch_v = (c == glc_pkg::CH_V);
         d.ch_e = (c == glc_pkg::CH_E);
         d.digit = (c[6:4] == 3'h3) && (c[3:0] <= 4'h9);
      end
      return d;
   endfunction

   // ==========================================
   // Handshake and strobe
   logic atn, dav, ren;
   logic [6:0] dio;
   glc_pkg::glc_dec_s dec;
   glc_pkg::glc_hs_e hs_reg, hs_next;
   logic [7:0] cnt_reg, cnt_next;
   logic stb_reg, stb_next;
   logic stb_q_reg;
   logic hs_en;
   logic mla;
   logic [4:0] my_addr_reg, my_addr_next;
   logic listen_reg, listen_next;
   logic remote_reg, remote_next;

   // Pins other than ifc_n are taken as synchronous to hclk
   assign atn = ~atn_n; // RULE_24
   assign dav = ~dav_n;
   assign ren = ~ren_n;
   assign dio = ~dio_n;
   assign dec = decode(atn, dio);
   assign hs_en = atn | listen_reg; // RULE_01
   assign mla = atn && (dio[4:0] == my_addr_reg); // RULE_06

   // Handshake sequencer with counted settle and strobe width
   always_comb begin
      hs_next = hs_reg;
      cnt_next = cnt_reg;
      stb_next = 1'b0;
      case (hs_reg)
         glc_pkg::HS_IDLE: begin
            if (dav && hs_en) begin
               hs_next = glc_pkg::HS_SETTLE;
               cnt_next = 8'(SETTLE - 1);
            end
         end
         glc_pkg::HS_SETTLE: begin
            if (!dav) begin
               hs_next = glc_pkg::HS_IDLE; // RULE_04
            end else if (cnt_reg == 8'h00) begin
               hs_next = glc_pkg::HS_HELD; // RULE_03
               cnt_next = 8'(STROBE - 1);
               stb_next = 1'b1; // RULE_05
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         glc_pkg::HS_HELD: begin
            if (cnt_reg != 8'h00) begin
               cnt_next = cnt_reg - 8'h01;
               stb_next = 1'b1;
            end
            if (!dav) begin
               hs_next = glc_pkg::HS_IDLE; // RULE_04
               stb_next = 1'b0;
            end
         end
         default: hs_next = glc_pkg::HS_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hs_reg <= glc_pkg::HS_IDLE; // RULE_25
         cnt_reg <= 8'h00;
         stb_reg <= 1'b0;
         stb_q_reg <= 1'b0;
      end else begin
         hs_reg <= hs_next;
         cnt_reg <= cnt_next;
         stb_reg <= stb_next;
         stb_q_reg <= stb_reg;
      end
   end

   // Strobe edges: leading edge acts, trailing edge captures M and B
   logic stb_rise, stb_fall;
   assign stb_rise = stb_reg & ~stb_q_reg;
   assign stb_fall = ~stb_reg & stb_q_reg;

   // Handshake line drive; NDAC stays low until a byte is taken, so a source never sees a false accept
   logic drive;
   assign drive = hs_en && (hs_next == glc_pkg::HS_HELD); // RULE_02
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nrfd_o <= 1'b1;
         ndac_o <= 1'b1;
         nrfd_oe_n <= 1'b1; // RULE_25
         ndac_oe_n <= 1'b1;
      end else begin
         nrfd_o <= ~drive; // RULE_03
         ndac_o <= drive; // RULE_03
         nrfd_oe_n <= ~hs_en; // RULE_02
         ndac_oe_n <= ~hs_en;
      end
   end

   // ==========================================
   // Listen, remote and marker
   logic marker_reg, marker_next;
   // Data decoding only while listening or addressed
   logic dstb;
   assign dstb = stb_rise & (listen_reg | atn); // RULE_05

   always_comb begin
      listen_next = listen_reg;
      remote_next = remote_reg;
      marker_next = marker_reg;
      if (dstb && mla && !dec.unlisten) listen_next = 1'b1; // RULE_09
      else if (dstb && !mla && dec.unlisten) listen_next = 1'b0;
      if (!ren) remote_next = 1'b0; // RULE_11
      else if (mla || dstb) remote_next = 1'b1;
      if (dstb && !atn && dec.ch_r) marker_next = 1'b1; // RULE_12
      else if (dstb && !atn && dec.ch_l) marker_next = 1'b0;
      if (!ren) marker_next = 1'b0; // RULE_13
   end

   // Interface clear acts asynchronously on listen
   always_ff @(posedge hclk or negedge hresetn or negedge ifc_n) begin
      if (!hresetn) begin
         listen_reg <= 1'b0;
      end else if (!ifc_n) begin
         listen_reg <= 1'b0; // RULE_10
      end else begin
         listen_reg <= listen_next;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         remote_reg <= 1'b0;
         marker_reg <= 1'b0;
      end else begin
         remote_reg <= remote_next;
         marker_reg <= marker_next;
      end
   end

   // ==========================================
   // Mode, band and voltage entry
   logic m_cap_reg, m_cap_next, b_cap_reg, b_cap_next;
   logic [3:0] mode_reg, mode_next;
   logic rce_reg, rce_next;
   logic [3:0] band_reg, band_next;
   logic rbl_next;
   logic ventry_reg, ventry_next;
   logic [15:0] shift_reg, shift_next;
   logic [15:0] store_reg, store_next;
   logic dstrobe, dd, dig_1to4;
   assign dd = dstb & ~atn;
   assign dig_1to4 = dec.digit && (dio[3:0] >= 4'h1) && (dio[3:0] <= 4'h4);

   always_comb begin
      m_cap_next = m_cap_reg;
      b_cap_next = b_cap_reg;
      mode_next = mode_reg;
      rce_next = rce_reg;
      band_next = band_reg;
      ventry_next = ventry_reg;
      shift_next = shift_reg;
      store_next = store_reg;
      dstrobe = dd & m_cap_reg;
      rbl_next = dd & b_cap_reg; // RULE_17
      if (stb_fall) begin
         m_cap_next = dec.ch_m & listen_reg; // RULE_14
         b_cap_next = dec.ch_b & listen_reg; // RULE_17
      end
      if (dstrobe) begin
         rce_next = dig_1to4; // RULE_16
         if (dig_1to4) mode_next = 4'h1 << (dio[1:0] - 2'h1); // RULE_15
      end
      if (rbl_next && dig_1to4) band_next = 4'h1 << (dio[1:0] - 2'h1); // RULE_18
      if (dd && dec.ch_v) begin
         ventry_next = 1'b1; // RULE_19
         shift_next = 16'h0000;
      end else if (dd && dec.digit) begin
         shift_next = {shift_reg[11:0], dio[3:0]}; // RULE_20
      end
      if (dd && (dec.ch_e || (ventry_reg && (dec.ch_b || dec.ch_m)))) begin
         store_next = shift_reg; // RULE_21 RULE_23
         ventry_next = 1'b0;
      end
      if (!remote_reg) mode_next = 4'h0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         m_cap_reg <= 1'b0;
         b_cap_reg <= 1'b0;
         mode_reg <= 4'h0;
         rce_reg <= 1'b0;
         band_reg <= 4'h0;
         remote_band_latch_enable <= 1'b0;
         ventry_reg <= 1'b0;
         shift_reg <= glc_pkg::TUNE_RST;
         store_reg <= glc_pkg::TUNE_RST;
      end else begin
         m_cap_reg <= m_cap_next;
         b_cap_reg <= b_cap_next;
         mode_reg <= mode_next;
         rce_reg <= rce_next;
         band_reg <= band_next;
         remote_band_latch_enable <= rbl_next;
         ventry_reg <= ventry_next;
         shift_reg <= shift_next;
         store_reg <= store_next;
      end
   end

   // Output registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         remote_o <= 1'b0;
         listen_o <= 1'b0;
         remote_marker_enable_n <= 1'b1;
         local_mode_disable_n <= 1'b1;
         mode_sel_n <= 4'hF;
         remote_converter_enable <= 1'b0;
         band_sel <= 4'h0;
         tune_code <= glc_pkg::TUNE_RST;
      end else begin
         remote_o <= remote_reg;
         listen_o <= listen_reg;
         remote_marker_enable_n <= ~marker_reg; // RULE_12
         local_mode_disable_n <= ~remote_reg; // RULE_14
         mode_sel_n <= ~mode_reg; // RULE_15
         remote_converter_enable <= rce_reg;
         band_sel <= band_reg;
         tune_code <= store_reg; // RULE_22
      end
   end

   // ==========================================
   // AHB-Lite slave: zero wait states
   logic ph_reg, ph_next, wr_reg, wr_next;
   logic [7:0] ad_reg, ad_next;
   logic [31:0] rd_next;

   always_comb begin
      ph_next = hsel && hready && htrans[1];
      wr_next = hwrite;
      ad_next = haddr[7:0];
      my_addr_next = my_addr_reg;
      if (ph_reg && wr_reg && ad_reg == glc_pkg::ADDR_CTRL) my_addr_next = hwdata[4:0];
      rd_next = 32'h0;
      case (haddr[7:0])
         glc_pkg::ADDR_CTRL: rd_next = {27'h0, my_addr_reg};
         glc_pkg::ADDR_STAT: rd_next = {26'h0, ventry_reg, marker_reg, remote_reg, listen_reg, hs_reg};
         glc_pkg::ADDR_TUNE: rd_next = {16'h0, store_reg};
         glc_pkg::ADDR_SHIFT: rd_next = {16'h0, shift_reg};
         default: rd_next = 32'h0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_reg <= 1'b0;
         wr_reg <= 1'b0;
         ad_reg <= 8'h00;
         my_addr_reg <= glc_pkg::ADDR_RST;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         ph_reg <= ph_next;
         wr_reg <= wr_next;
         ad_reg <= ad_next;
         my_addr_reg <= my_addr_next;
         hrdata <= (ph_next && !hwrite) ? rd_next : 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ==========================================
   // Checks
   sequence s_strobe_start;
      $rose(stb_reg);
   endsequence
   a_settle_before_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
      (hs_reg == glc_pkg::HS_SETTLE && dav && cnt_reg == 8'h00) |=> hs_reg == glc_pkg::HS_HELD)
      else $error("handshake did not hold after settle");
   a_dav_release: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_04
      (hs_reg == glc_pkg::HS_HELD && !dav) |=> hs_reg == glc_pkg::HS_IDLE ##1 nrfd_o)
      else $error("NRFD not released after DAV high");
   a_strobe_width: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
      s_strobe_start |=> stb_reg || !dav)
      else $error("strobe too short");
   a_oe_gated: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
      !$past(hs_en) |-> nrfd_oe_n && ndac_oe_n)
      else $error("handshake lines driven while disabled");
   a_hs_enable: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
      (hs_reg == glc_pkg::HS_IDLE && dav && (atn || listen_reg)) |=> hs_reg == glc_pkg::HS_SETTLE)
      else $error("handshake did not start");
   a_remote_clear: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
      !ren |=> !remote_reg && !marker_reg)
      else $error("remote not cleared by REN");
   a_listen_set: assert property (@(posedge hclk) disable iff (!hresetn || !ifc_n) // RULE_09
      (dstb && mla && !dec.unlisten) |=> listen_reg)
      else $error("listen not set on address");
   a_store_load: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_21
      (dd && dec.ch_e) |=> store_reg == $past(shift_reg) && !ventry_reg ##1 tune_code == $past(shift_reg, 2))
      else $error("storage not loaded on E");
   a_shift_digit: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_20
      (dd && dec.digit) |=> shift_reg[3:0] == $past(dio[3:0]))
      else $error("digit not shifted");
endmodule

// file: glc_ctl_model.sv
// Bus controller model that sources bytes over the three-wire handshake
`timescale 1ns/100ps
module glc_ctl_model (
   // Clock
   input wire logic hclk,
   // Lines driven towards the listener
   output logic atn_n,
   output logic dav_n,
   output logic [6:0] dio_n,
   // Handshake lines from the listener
   input wire logic nrfd_o,
   input wire logic nrfd_oe_n,
   input wire logic ndac_o,
   input wire logic ndac_oe_n
);
   // ==========
   // Wire levels: the bus terminations pull released lines high
   logic nrfd_w;
   logic ndac_w;
   assign nrfd_w = (nrfd_oe_n === 1'b0) ? nrfd_o : 1'b1;
   assign ndac_w = (ndac_oe_n === 1'b0) ? ndac_o : 1'b1;
   initial begin
      atn_n = 1'b1;
      dav_n = 1'b1;
      dio_n = 7'h7F;
   end
   // One byte; ok is true when acceptance held and then cleared
   task automatic send(input logic atn, input logic [6:0] ch, output logic ok);
      int n;
      @(posedge hclk);
      atn_n <= ~atn;
      dio_n <= ~ch;
      @(posedge hclk);
      dav_n <= 1'b0; // Data settles a cycle before it is flagged
      n = 0;
      while (nrfd_w !== 1'b0 && n < 40) begin
         @(posedge hclk);
         n++;
      end
      // Acceptance must still stand a few cycles on
      repeat (4) @(posedge hclk);
      ok = (nrfd_w === 1'b0) && (ndac_w === 1'b1);
      dav_n <= 1'b1;
      n = 0;
      while (nrfd_w !== 1'b1 && n < 40) begin
         @(posedge hclk);
         n++;
      end
      // An enabled listener holds NDAC low again once the byte is done
      ok = ok && (nrfd_w === 1'b1) && (ndac_w === 1'b0);
      repeat (4) @(posedge hclk);
      atn_n <= 1'b1;
      dio_n <= 7'h7F; // Released lines float high
   endtask
endmodule

// file: glc_listener_tb.sv
// Self-checking bench for the listener command decoder
`timescale 1ns/100ps
module glc_listener_tb;
   // ==========
   // Signals
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, atn_n, dav_n, nrfd_o, nrfd_oe_n, ndac_o, ndac_oe_n;
   logic ifc_n = 1'b1;
   logic ren_n = 1'b1;
   logic [6:0] dio_n;
   logic remote_o, listen_o, remote_marker_enable_n, local_mode_disable_n;
   logic remote_converter_enable, remote_band_latch_enable;
   logic [3:0] mode_sel_n, band_sel;
   logic [15:0] tune_code, code;
   logic rd_pend = 1'b0;
   logic rbl_seen = 1'b0;
   logic ok;
   logic [4:0] my_addr;
   logic [31:0] seed = 32'hF6A190B5;
   logic [31:0] exp_q[$];
   int num_errors = 0;
   int comparisons = 0;

   // Short counts keep the run brief
   glc_listener #(.SETTLE(2), .STROBE(2)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .atn_n, .dav_n, .ifc_n, .ren_n,
      .dio_n, .nrfd_o, .nrfd_oe_n, .ndac_o, .ndac_oe_n, .remote_o, .listen_o, .remote_marker_enable_n,
      .local_mode_disable_n, .mode_sel_n, .remote_converter_enable, .remote_band_latch_enable,
      .band_sel, .tune_code);
   glc_ctl_model u_ctl (.hclk, .atn_n, .dav_n, .dio_n, .nrfd_o, .nrfd_oe_n, .ndac_o, .ndac_oe_n);

   // Clock
   always #12.5 hclk = ~hclk;

   // ==========
   // Tasks
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Bounded wait; a slave that never answers counts as a mismatch
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) num_errors++;
   endtask
   // Single word transfer; for a read, d is the expected data
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      if (!wr) exp_q.push_back(d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rd_pend <= ~wr;
      wait_ready();
      rd_pend <= 1'b0;
   endtask
   task automatic tx(input logic atn, input logic [6:0] ch, input logic acc);
      u_ctl.send(atn, ch, ok);
      chk(32'(ok), 32'(acc));
   endtask

   // Read data is taken at the edge that ends the data phase
   always @(posedge hclk) begin
      if (rd_pend === 1'b1 && hreadyout === 1'b1) begin
         chk(hrdata, exp_q.pop_front());
      end
   end
   // The band latch enable is only a pulse, so catch it
   always @(posedge hclk) begin
      if (remote_band_latch_enable === 1'b1) rbl_seen <= 1'b1;
   end
   // Watchdog
   initial begin
      repeat (8000) @(posedge hclk);
      num_errors++;
      finish_test();
   end

   // ==========
   // Main sequence
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      chk(32'({hresp, nrfd_oe_n, ndac_oe_n, mode_sel_n, remote_marker_enable_n}), 32'h7F);
      ahb(1'b0, glc_pkg::ADDR_STAT, 32'h0);
      ahb(1'b0, glc_pkg::ADDR_TUNE, 32'h0);
      // Random switch address, never all ones so unlisten cannot match it
      seed = lfsr(seed);
      my_addr = (seed[4:0] == 5'h1F) ? 5'h0A : seed[4:0];
      ahb(1'b1, glc_pkg::ADDR_CTRL, {seed[31:5], my_addr});
      ahb(1'b0, glc_pkg::ADDR_CTRL, {27'h0, my_addr});
      ahb(1'b1, 8'h40, seed);
      ahb(1'b0, 8'h40, 32'h0);
      tx(1'b0, glc_pkg::CH_R, 1'b0);
      ren_n <= 1'b0;
      tx(1'b1, {glc_pkg::LAG_GRP, my_addr}, 1'b1);
      ahb(1'b0, glc_pkg::ADDR_STAT, 32'hC);
      tx(1'b0, glc_pkg::CH_R, 1'b1);
      @(negedge hclk);
      chk(32'(remote_marker_enable_n), 32'h0);
      tx(1'b0, glc_pkg::CH_L, 1'b1);
      @(negedge hclk);
      chk(32'(remote_marker_enable_n), 32'h1);
      // Every mode and band digit
      for (int k = 1; k <= 4; k++) begin
         tx(1'b0, glc_pkg::CH_M, 1'b1);
         tx(1'b0, {3'h3, 4'(k)}, 1'b1);
         @(negedge hclk);
         chk(32'({mode_sel_n, remote_converter_enable, local_mode_disable_n}),
            32'({~(4'h1 << (k - 1)), 2'b10}));
         rbl_seen = 1'b0;
         tx(1'b0, glc_pkg::CH_B, 1'b1);
         tx(1'b0, {3'h3, 4'(k)}, 1'b1);
         @(negedge hclk);
         chk(32'({band_sel, rbl_seen}), 32'({4'h1 << (k - 1), 1'b1}));
      end
      // Four random digits, most significant first
      tx(1'b0, glc_pkg::CH_V, 1'b1);
      code = 16'h0;
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         code = {code[11:0], 4'(seed[7:0] % 10)};
         tx(1'b0, {3'h3, code[3:0]}, 1'b1);
      end
      ahb(1'b0, glc_pkg::ADDR_SHIFT, {16'h0, code});
      tx(1'b0, glc_pkg::CH_E, 1'b1);
      ahb(1'b0, glc_pkg::ADDR_TUNE, {16'h0, code});
      ahb(1'b0, glc_pkg::ADDR_STAT, 32'hC);
      chk(32'(tune_code), 32'(code));
      // A second entry cut short by M still loads the storage register
      tx(1'b0, glc_pkg::CH_V, 1'b1);
      ahb(1'b0, glc_pkg::ADDR_SHIFT, 32'h0);
      ahb(1'b0, glc_pkg::ADDR_STAT, 32'h2C);
      tx(1'b0, 7'h37, 1'b1);
      tx(1'b0, 7'h33, 1'b1);
      tx(1'b0, glc_pkg::CH_M, 1'b1);
      tx(1'b0, 7'h32, 1'b1);
      ahb(1'b0, glc_pkg::ADDR_TUNE, 32'h73);
      ahb(1'b0, glc_pkg::ADDR_STAT, 32'hC);
      // Dropping REN returns the instrument to local control
      tx(1'b0, glc_pkg::CH_R, 1'b1);
      ren_n <= 1'b1;
      repeat (8) @(negedge hclk);
      chk(32'({remote_o, remote_marker_enable_n, local_mode_disable_n, mode_sel_n}), 32'h3F);
      // Unlisten, then data bytes go unanswered
      tx(1'b1, glc_pkg::CH_UNL, 1'b1);
      @(negedge hclk);
      chk(32'(listen_o), 32'h0);
      tx(1'b0, glc_pkg::CH_R, 1'b0);
      // Interface clear drops listen with no strobe
      tx(1'b1, {glc_pkg::LAG_GRP, my_addr}, 1'b1);
      ifc_n <= 1'b0;
      repeat (2) @(posedge hclk);
      ifc_n <= 1'b1;
      @(negedge hclk);
      chk(32'(listen_o), 32'h0);
      tx(1'b0, glc_pkg::CH_R, 1'b0);
      finish_test();
   end
endmodule
